// ---- inc/ccr_pkg.sv ----
// Constants, register layout and link timing shared by both link ends.
// Assumes both ends run from one 10 MHz clock that stands in for the
// converter master clock.
// Operation
// - Offset word corrects every stored conversion result
// - Host reads and writes offset register serially
// - Offset word always two's complement
// - Offset correction is linear in stored word
// - Full-scale word gain-corrects every stored result
// - Host reads and writes full-scale register serially
// - Full-scale word always unsigned binary
// - Gain correction is linear in stored word
// - Registers are bytes 23:16, 15:8, 7:0
// - Calibration leaves its values in both registers
// - Host may average calibrations, write back
// - Master mode clock phases two master periods
// - Slave mode clock phases at least five periods
// - Result in two's complement or offset binary
// - Calibration modes return to normal automatically
package ccr_pkg;
  // Word and frame layout
  localparam int WORD_W = 24;
  localparam int FRAME_BITS = 32;
  localparam int INSTR_BITS = 8;
  localparam int SEL_BITS = 3;
  localparam int FCR_FRAC = 22;
  // Instruction: bit 7 read, bits 6:5 register select
  localparam int INSTR_RW_BIT = 7;
  localparam logic [1:0] SEL_OFFSET = 2'h0;
  localparam logic [1:0] SEL_FULLSCALE = 2'h1;
  localparam logic [1:0] SEL_RESULT = 2'h2;
  localparam logic [1:0] SEL_CTRL = 2'h3;
  // Device control word: [2:0] operating mode, [3] output format
  localparam int CTL_FMT_BIT = 3;
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_SELF = 3'h1;
  localparam logic [2:0] MODE_SYS_OFFSET = 3'h2;
  localparam logic [2:0] MODE_SYS_FULLSCALE = 3'h3;
  localparam logic [2:0] MODE_PSEUDO = 3'h4;
  // Reset values and saturation limits
  localparam logic [23:0] OFFSET_RESET = 24'h000000;
  localparam logic [23:0] FULLSCALE_RESET = 24'h400000;
  localparam logic [3:0] CTL_RESET = 4'h0;
  localparam logic [23:0] SAT_POS = 24'h7FFFFF;
  localparam logic [23:0] SAT_NEG = 24'h800000;
  // Link timing in master clock periods
  localparam int MASTER_HALF_CYCLES = 2;
  localparam int SLAVE_MIN_HALF_CYCLES = 5;
  localparam int HOST_HALF_CYCLES = SLAVE_MIN_HALF_CYCLES + 1;
  localparam int MASTER_PHASES = 2 * FRAME_BITS;
  localparam int RISE_DLY = 4;
  localparam int LEAD_CYCLES = 12;
  localparam int TAIL_CYCLES = HOST_HALF_CYCLES;
  // Host register offsets and control fields
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WDATA = 8'h04;
  localparam logic [7:0] ADDR_RDATA = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int CTRL_RW_BIT = 3;
  localparam int CTRL_MASTER_BIT = 4;
endpackage

// ---- inc/ccr_link_if.sv ----
// Serial link between the converter end and the host end.
// The shared clock wire is resolved here from the two enables.
`timescale 1ns/1ns
interface ccr_link_if;
  logic sclk_dev_o;
  logic sclk_dev_oe_n;
  logic sclk_host_o;
  logic sclk_host_oe_n;
  logic sclk;
  logic sdi;
  logic serial_data_out;
  logic cs_n;
  logic result_ready_n;
  // Idle wire reads low when nobody drives it
  assign sclk = !sclk_dev_oe_n ? sclk_dev_o : (!sclk_host_oe_n ? sclk_host_o : 1'b0);
  modport dev (output sclk_dev_o, output sclk_dev_oe_n, input sclk, input sdi,
    output serial_data_out, input cs_n, output result_ready_n);
  modport host (output sclk_host_o, output sclk_host_oe_n, input sclk, output sdi,
    input serial_data_out, output cs_n, input result_ready_n);
endinterface

// ---- core/ccr_device.sv ----
// Converter end: correction registers, result path, serial slave/master.
// Assumes link pins are asynchronous to hclk and raw samples arrive as
// one-cycle strobes from logic on hclk.
`timescale 1ns/1ns
module ccr_device
  import ccr_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link
  ccr_link_if.dev link,
  // Modulator side
  input wire logic [WORD_W-1:0] raw_sample,
  input wire logic raw_valid,
  input wire logic sclk_master,
  // Result
  output logic [WORD_W-1:0] conversion_result
);
  typedef enum logic [1:0] {LS_IDLE, LS_SHIFT, LS_END} ccr_lstate_t;

  // Input synchronisers
  logic sclk_s1, sclk_s2, sdi_s1, sdi_s2, cs_s1, cs_s2;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
    end
    else
    begin
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sdi_s1 <= link.sdi;
      sdi_s2 <= sdi_s1;
      cs_s1 <= link.cs_n;
      cs_s2 <= cs_s1;
    end
  end

  ccr_lstate_t state_reg, state_next;
  logic [WORD_W-1:0] offset_correction_reg, offset_correction_next;
  logic [WORD_W-1:0] fullscale_correction_reg, fullscale_correction_next;
  logic [3:0] ctl_reg, ctl_next;
  logic [WORD_W-1:0] result_reg, result_next;
  logic result_ready_n_n_reg, result_ready_n_n_next;
  logic sclk_gen_reg, sclk_gen_next;
  logic sclk_oe_n_reg, sclk_oe_n_next;
  logic [1:0] div_reg, div_next;
  logic [6:0] phase_reg, phase_next;
  logic sclk_prev_reg, sclk_prev_next;
  logic [RISE_DLY-1:0] rise_dly_reg, rise_dly_next;
  logic [FRAME_BITS-1:0] rx_reg, rx_next;
  logic [5:0] rx_cnt_reg, rx_cnt_next;
  logic [5:0] fall_cnt_reg, fall_cnt_next;
  logic [WORD_W-1:0] out_reg, out_next;
  logic serial_data_out_reg, serial_data_out_next;

  // Correction datapath, signed offset and unsigned gain
  logic signed [24:0] diff;
  logic signed [49:0] prod;
  logic signed [49:0] scaled;
  logic [WORD_W-1:0] corrected;
  logic [WORD_W-1:0] formatted;
  always_comb
  begin
    diff = $signed({raw_sample[23], raw_sample})
      - $signed({offset_correction_reg[23], offset_correction_reg});
    prod = diff * $signed({1'b0, fullscale_correction_reg});
    scaled = prod >>> FCR_FRAC;
    // Saturate instead of wrapping when gain pushes past full scale
    if (scaled[49:23] == {27{scaled[49]}})
      corrected = scaled[23:0];
    else if (scaled[49])
      corrected = SAT_NEG;
    else
      corrected = SAT_POS;
    if (ctl_reg[CTL_FMT_BIT])
      formatted = {~corrected[23], corrected[22:0]};
    else
      formatted = corrected;
  end

  // Register selected for readback, byte 2 shifts out first
  function automatic logic [WORD_W-1:0] read_sel(input logic [1:0] sel);
    logic [WORD_W-1:0] v;
    v = result_reg;
    if (sel == SEL_OFFSET)
      v = offset_correction_reg;
    else if (sel == SEL_FULLSCALE)
      v = fullscale_correction_reg;
    else if (sel == SEL_CTRL)
      v = {20'h00000, ctl_reg};
    return v;
  endfunction

  // Link engine, registers and conversion path
  logic sclk_now, rise, fall, sample;
  logic [FRAME_BITS-1:0] word;
  always_comb
  begin
    state_next = state_reg;
    offset_correction_next = offset_correction_reg;
    fullscale_correction_next = fullscale_correction_reg;
    ctl_next = ctl_reg;
    result_next = result_reg;
    result_ready_n_n_next = result_ready_n_n_reg;
    sclk_gen_next = sclk_gen_reg;
    sclk_oe_n_next = ~sclk_master;
    div_next = div_reg;
    phase_next = phase_reg;
    rx_next = rx_reg;
    rx_cnt_next = rx_cnt_reg;
    fall_cnt_next = fall_cnt_reg;
    out_next = out_reg;
    serial_data_out_next = serial_data_out_reg;
    sclk_now = sclk_master ? sclk_gen_reg : sclk_s2;
    rise = sclk_now & ~sclk_prev_reg;
    fall = ~sclk_now & sclk_prev_reg;
    // Own clock loops back through the host, so sample late
    sample = sclk_master ? rise_dly_reg[RISE_DLY-1] : rise;
    sclk_prev_next = sclk_now;
    rise_dly_next = {rise_dly_reg[RISE_DLY-2:0], rise};
    word = {rx_reg[FRAME_BITS-2:0], sdi_s2};
    // Clock generator, two master periods per phase
    if (sclk_master && !cs_s2 && phase_reg < 7'(MASTER_PHASES))
    begin
      if (div_reg == 2'(MASTER_HALF_CYCLES - 1))
      begin
        div_next = 2'h0;
        sclk_gen_next = ~sclk_gen_reg;
        phase_next = phase_reg + 7'h01;
      end
      else
        div_next = div_reg + 2'h1;
    end
    else if (cs_s2 || !sclk_master)
    begin
      div_next = 2'h0;
      phase_next = 7'h00;
      sclk_gen_next = 1'b0;
    end
    case (state_reg)
      LS_IDLE:
      begin
        if (!cs_s2)
        begin
          state_next = LS_SHIFT;
          rx_cnt_next = 6'h00;
          fall_cnt_next = 6'h00;
          out_next = '0;
          serial_data_out_next = 1'b0;
        end
      end
      LS_SHIFT:
      begin
        if (cs_s2)
          state_next = LS_IDLE;
        else
        begin
          if (sample)
          begin
            rx_next = word;
            rx_cnt_next = rx_cnt_reg + 6'h01;
            if (rx_cnt_reg == 6'(SEL_BITS - 1))
              out_next = read_sel(word[1:0]);
            if (rx_cnt_reg == 6'(FRAME_BITS - 1))
            begin
              state_next = LS_END;
              if (!word[INSTR_RW_BIT + WORD_W])
              begin
                // Byte 2 arrives first, so MSB lands in bit 23
                if (word[30:29] == SEL_OFFSET)
                  offset_correction_next = word[23:0];
                else if (word[30:29] == SEL_FULLSCALE)
                  fullscale_correction_next = word[23:0];
                else if (word[30:29] == SEL_CTRL)
                  ctl_next = word[3:0];
              end
              else if (word[30:29] == SEL_RESULT)
                result_ready_n_n_next = 1'b1;
            end
          end
          if (fall && fall_cnt_reg < 6'(FRAME_BITS))
          begin
            fall_cnt_next = fall_cnt_reg + 6'h01;
            if (fall_cnt_reg >= 6'(INSTR_BITS - 1))
            begin
              serial_data_out_next = out_reg[WORD_W-1];
              out_next = {out_reg[WORD_W-2:0], 1'b0};
            end
          end
        end
      end
      default:
      begin
        if (cs_s2)
          state_next = LS_IDLE;
      end
    endcase
    // Conversion uses register values as they stand this cycle
    if (raw_valid)
    begin
      case (ctl_reg[2:0])
        MODE_SELF, MODE_PSEUDO:
        begin
          offset_correction_next = raw_sample;
          fullscale_correction_next = FULLSCALE_RESET;
          ctl_next[2:0] = MODE_NORMAL;
        end
        MODE_SYS_OFFSET:
        begin
          offset_correction_next = raw_sample;
          ctl_next[2:0] = MODE_NORMAL;
        end
        MODE_SYS_FULLSCALE:
        begin
          fullscale_correction_next = FULLSCALE_RESET;
          ctl_next[2:0] = MODE_NORMAL;
        end
        default:
        begin
          result_next = formatted;
          result_ready_n_n_next = 1'b0;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= LS_IDLE;
      offset_correction_reg <= OFFSET_RESET;
      fullscale_correction_reg <= FULLSCALE_RESET;
      ctl_reg <= CTL_RESET;
      result_reg <= '0;
      result_ready_n_n_reg <= 1'b1;
      sclk_gen_reg <= 1'b0;
      sclk_oe_n_reg <= 1'b1;
      div_reg <= 2'h0;
      phase_reg <= 7'h00;
      sclk_prev_reg <= 1'b0;
      rise_dly_reg <= '0;
      rx_reg <= '0;
      rx_cnt_reg <= 6'h00;
      fall_cnt_reg <= 6'h00;
      out_reg <= '0;
      serial_data_out_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      offset_correction_reg <= offset_correction_next;
      fullscale_correction_reg <= fullscale_correction_next;
      ctl_reg <= ctl_next;
      result_reg <= result_next;
      result_ready_n_n_reg <= result_ready_n_n_next;
      sclk_gen_reg <= sclk_gen_next;
      sclk_oe_n_reg <= sclk_oe_n_next;
      div_reg <= div_next;
      phase_reg <= phase_next;
      sclk_prev_reg <= sclk_prev_next;
      rise_dly_reg <= rise_dly_next;
      rx_reg <= rx_next;
      rx_cnt_reg <= rx_cnt_next;
      fall_cnt_reg <= fall_cnt_next;
      out_reg <= out_next;
      serial_data_out_reg <= serial_data_out_next;
    end
  end

  // Outputs straight from flops
  assign link.sclk_dev_o = sclk_gen_reg;
  assign link.sclk_dev_oe_n = sclk_oe_n_reg;
  assign link.serial_data_out = serial_data_out_reg;
  assign link.result_ready_n = result_ready_n_n_reg;
  assign conversion_result = result_reg;
endmodule

// ---- core/ccr_host.sv ----
// Host end: AHB-Lite register slave that runs serial frames to the device.
// Assumes one AHB master, single word transfers, link pins asynchronous.
`timescale 1ns/1ns
module ccr_host
  import ccr_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Link
  ccr_link_if.host link
);
  typedef enum logic [1:0] {HS_IDLE, HS_LEAD, HS_RUN, HS_TAIL} ccr_hstate_t;

  // Input synchronisers
  logic sclk_s1, sclk_s2, sdo_s1, sdo_s2, rdy_s1, rdy_s2;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sdo_s1 <= 1'b0;
      sdo_s2 <= 1'b0;
      rdy_s1 <= 1'b1;
      rdy_s2 <= 1'b1;
    end
    else
    begin
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sdo_s1 <= link.serial_data_out;
      sdo_s2 <= sdo_s1;
      rdy_s1 <= link.result_ready_n;
      rdy_s2 <= rdy_s1;
    end
  end

  ccr_hstate_t state_reg, state_next;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic [4:1] ctrl_reg, ctrl_next;
  logic [WORD_W-1:0] wdata_reg, wdata_next;
  logic [WORD_W-1:0] rdata_reg, rdata_next;
  logic [FRAME_BITS-1:0] tx_reg, tx_next;
  logic [FRAME_BITS-1:0] rx_reg, rx_next;
  logic [5:0] rise_cnt_reg, rise_cnt_next;
  logic [3:0] cnt_reg, cnt_next;
  logic sclk_gen_reg, sclk_gen_next;
  logic sclk_prev_reg, sclk_prev_next;
  logic cs_n_reg, cs_n_next;
  logic sdi_reg, sdi_next;
  logic oe_n_reg, oe_n_next;
  logic rdy_out_reg;

  // Bus slave and frame engine
  logic master;
  logic rise, fall;
  logic [31:0] status;
  always_comb
  begin
    state_next = state_reg;
    wr_pend_next = 1'b0;
    wr_addr_next = wr_addr_reg;
    hrdata_next = hrdata_reg;
    ctrl_next = ctrl_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    rise_cnt_next = rise_cnt_reg;
    cnt_next = cnt_reg;
    sclk_gen_next = sclk_gen_reg;
    sclk_prev_next = sclk_s2;
    cs_n_next = cs_n_reg;
    sdi_next = sdi_reg;
    master = ctrl_reg[CTRL_MASTER_BIT];
    oe_n_next = master;
    rise = 1'b0;
    fall = 1'b0;
    status = {30'h00000000, ~rdy_s2, state_reg != HS_IDLE};
    // Address phase: latch writes, prepare read data
    if (hsel && htrans[1] && hready)
    begin
      wr_pend_next = hwrite;
      wr_addr_next = haddr[7:0];
      if (haddr[7:0] == ADDR_CTRL)
        hrdata_next = {27'h0000000, ctrl_reg, 1'b0};
      else if (haddr[7:0] == ADDR_WDATA)
        hrdata_next = {8'h00, wdata_reg};
      else if (haddr[7:0] == ADDR_RDATA)
        hrdata_next = {8'h00, rdata_reg};
      else if (haddr[7:0] == ADDR_STATUS)
        hrdata_next = status;
      else
        hrdata_next = 32'h00000000;
    end
    // Data phase writes
    if (wr_pend_reg)
    begin
      if (wr_addr_reg == ADDR_CTRL)
      begin
        ctrl_next = hwdata[4:1];
        // Start refused while a frame runs
        if (hwdata[CTRL_GO_BIT] && state_reg == HS_IDLE)
        begin
          // Read bit goes straight onto sdi, the rest waits in the shifter
          tx_next = {hwdata[CTRL_SEL_LSB+:2], 5'h00, wdata_reg, 1'b0};
          sdi_next = hwdata[CTRL_RW_BIT];
          cs_n_next = 1'b0;
          rise_cnt_next = 6'h00;
          cnt_next = 4'h0;
          sclk_gen_next = 1'b0;
          state_next = hwdata[CTRL_MASTER_BIT] ? HS_RUN : HS_LEAD;
        end
      end
      else if (wr_addr_reg == ADDR_WDATA)
        wdata_next = hwdata[WORD_W-1:0];
    end
    case (state_reg)
      HS_LEAD:
      begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == 4'(LEAD_CYCLES - 1))
        begin
          cnt_next = 4'h0;
          state_next = HS_RUN;
        end
      end
      HS_RUN:
      begin
        if (master)
        begin
          rise = sclk_s2 & ~sclk_prev_reg;
          fall = ~sclk_s2 & sclk_prev_reg;
        end
        else
        begin
          cnt_next = cnt_reg + 4'h1;
          // Phases kept above the device's least figure
          if (cnt_reg == 4'(HOST_HALF_CYCLES - 1))
          begin
            cnt_next = 4'h0;
            sclk_gen_next = ~sclk_gen_reg;
            rise = ~sclk_gen_reg;
            fall = sclk_gen_reg;
          end
        end
        if (fall)
        begin
          sdi_next = tx_reg[FRAME_BITS-1];
          tx_next = {tx_reg[FRAME_BITS-2:0], 1'b0};
        end
        if (rise)
        begin
          rx_next = {rx_reg[FRAME_BITS-2:0], sdo_s2};
          rise_cnt_next = rise_cnt_reg + 6'h01;
          if (rise_cnt_reg == 6'(FRAME_BITS - 1))
          begin
            cnt_next = 4'h0;
            state_next = HS_TAIL;
          end
        end
      end
      HS_TAIL:
      begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == 4'(TAIL_CYCLES - 1))
        begin
          sclk_gen_next = 1'b0;
          cs_n_next = 1'b1;
          sdi_next = 1'b0;
          if (ctrl_reg[CTRL_RW_BIT])
            rdata_next = rx_reg[WORD_W-1:0];
          state_next = HS_IDLE;
        end
      end
      default:
      begin
      end
    endcase
  end

  // State registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= HS_IDLE;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
      ctrl_reg <= 4'h0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      tx_reg <= '0;
      rx_reg <= '0;
      rise_cnt_reg <= 6'h00;
      cnt_reg <= 4'h0;
      sclk_gen_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      sdi_reg <= 1'b0;
      oe_n_reg <= 1'b0;
      rdy_out_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
      ctrl_reg <= ctrl_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      rise_cnt_reg <= rise_cnt_next;
      cnt_reg <= cnt_next;
      sclk_gen_reg <= sclk_gen_next;
      sclk_prev_reg <= sclk_prev_next;
      cs_n_reg <= cs_n_next;
      sdi_reg <= sdi_next;
      oe_n_reg <= oe_n_next;
      rdy_out_reg <= 1'b1;
    end
  end

  // Zero-wait OKAY slave, hresp tied low, other outputs from flops
  assign hrdata = hrdata_reg;
  assign hreadyout = rdy_out_reg;
  assign hresp = 1'b0;
  assign link.sclk_host_o = sclk_gen_reg;
  assign link.sclk_host_oe_n = oe_n_reg;
  assign link.cs_n = cs_n_reg;
  assign link.sdi = sdi_reg;
endmodule

// ---- verif/ccr_assertions.sv ----
// Checker for the serial link between the converter end and the host end.
// Assumes one hclk domain and the plain signals of the link interface.
`timescale 1ns/1ns
module ccr_assertions
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link
  input wire logic sclk_dev_o,
  input wire logic sclk_dev_oe_n,
  input wire logic sclk_host_o,
  input wire logic sclk_host_oe_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic serial_data_out,
  input wire logic cs_n,
  input wire logic result_ready_n
);
  logic sclk_q_reg;
  logic [5:0] n_rise_reg;
  logic [5:0] n_rise_next;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Count clock rises inside a frame; cleared while deselected
  always_comb
  begin
    n_rise_next = n_rise_reg;
    if (cs_n)
      n_rise_next = 6'h00;
    else if (sclk && !sclk_q_reg)
      n_rise_next = n_rise_reg + 6'h01;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sclk_q_reg <= 1'b0;
      n_rise_reg <= 6'h00;
    end
    else
    begin
      sclk_q_reg <= sclk;
      n_rise_reg <= n_rise_next;
    end
  end
  a_master_high: assert property (
    $rose(sclk_dev_o) && !sclk_dev_oe_n && !cs_n |-> sclk_dev_o[*2] ##1 !sclk_dev_o)
    else $error("device clock high phase wrong");
  a_master_low: assert property (
    $fell(sclk_dev_o) && !sclk_dev_oe_n && !cs_n |-> !sclk_dev_o[*2])
    else $error("device clock low phase short");
  a_slave_high: assert property (
    $rose(sclk_host_o) && !sclk_host_oe_n && !cs_n |-> sclk_host_o[*5])
    else $error("host clock high phase short");
  a_slave_low: assert property (
    $fell(sclk_host_o) && !sclk_host_oe_n && !cs_n |-> !sclk_host_o[*5])
    else $error("host clock low phase short");
  a_idle_still: assert property (
    cs_n[*3] |-> !sclk)
    else $error("link clock moves outside a frame");
  a_one_driver: assert property (
    !cs_n |-> sclk_dev_oe_n != sclk_host_oe_n)
    else $error("clock wire driver not unique in frame");
  a_sdi_on_low: assert property (
    !$stable(sdi) && !cs_n && !sclk_host_oe_n |-> !sclk)
    else $error("host data moved while clock high");
  a_serial_data_out_on_low: assert property (
    !$stable(serial_data_out) && !cs_n && !sclk_host_oe_n |-> !sclk)
    else $error("device data moved while clock high");
  a_frame_bits: assert property (
    cs_n && !$past(cs_n) |-> n_rise_reg == 6'h20)
    else $error("frame not 32 clock rises");
  // Main scenarios seen
  c_master: cover property ($rose(sclk_dev_o) && !cs_n);
  c_slave: cover property ($rose(sclk_host_o) && !cs_n);
  c_ready: cover property ($fell(result_ready_n));
endmodule

// ---- verif/ccr_tb.sv ----
// Self-checking bench: both link ends joined, host driven over AHB-Lite.
// Assumes the package timing and register map; expectations from a model.
`timescale 1ns/1ns
module ccr_tb
  import ccr_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [23:0] raw_sample = 24'h000000;
  logic raw_valid = 1'b0;
  logic sclk_master = 1'b0;
  logic [23:0] conversion_result;
  logic [31:0] seed = 32'h0000005B;
  logic mstr = 1'b0;
  logic m_fmt;
  logic [23:0] m_off;
  logic [23:0] m_fs;
  logic [23:0] m_res;
  int n_errors = 0;
  int num_checks = 0;
  ccr_link_if link_i();
  ccr_device u_ccr_device(.hclk(hclk), .hresetn(hresetn), .link(link_i),
    .raw_sample(raw_sample), .raw_valid(raw_valid), .sclk_master(sclk_master),
    .conversion_result(conversion_result));
  ccr_host u_ccr_host(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link_i));
  ccr_assertions u_ccr_assertions(.hclk(hclk), .hresetn(hresetn),
    .sclk_dev_o(link_i.sclk_dev_o), .sclk_dev_oe_n(link_i.sclk_dev_oe_n),
    .sclk_host_o(link_i.sclk_host_o), .sclk_host_oe_n(link_i.sclk_host_oe_n),
    .sclk(link_i.sclk), .sdi(link_i.sdi), .serial_data_out(link_i.serial_data_out), .cs_n(link_i.cs_n),
    .result_ready_n(link_i.result_ready_n));
  // 100 ns clock
  always #50 hclk = ~hclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
  endfunction
  // Model: exact gains only, so rounding style cannot matter
  function automatic logic [23:0] model(input logic [23:0] raw);
    longint p;
    p = (longint'($signed(raw)) - longint'($signed(m_off))) * longint'(m_fs);
    p = p / 64'sh400000;
    if (p > 64'sh7FFFFF)
      p = 64'sh7FFFFF;
    if (p < -64'sh800000)
      p = -64'sh800000;
    return {p[23] ^ m_fmt, p[22:0]};
  endfunction
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Hold until hready seen high at a rising edge; data sampled just before it
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    int k;
    k = 0;
    do
    begin
      @(negedge hclk);
      r = hreadyout;
      d = hrdata;
      @(posedge hclk);
      k++;
    end
    while (r !== 1'b1 && k < 20);
    if (r !== 1'b1)
    begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy(rd);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(rd);
  endtask
  // One serial frame, busy polled under a bound
  task automatic link(input logic [1:0] sel, input logic rd, input logic [23:0] wd,
    output logic [23:0] q);
    logic [31:0] r;
    int k;
    ahb(1'b1, ADDR_WDATA, {8'h00, wd}, r);
    ahb(1'b1, ADDR_CTRL, {27'h0000000, mstr, rd, sel, 1'b1}, r);
    k = 0;
    do
    begin
      ahb(1'b0, ADDR_STATUS, 32'h00000000, r);
      k++;
    end
    while (r[0] !== 1'b0 && k < 500);
    if (r[0] !== 1'b0)
    begin
      n_errors++;
      close_out();
    end
    ahb(1'b0, ADDR_RDATA, 32'h00000000, r);
    q = r[23:0];
  endtask
  task automatic conv(input logic [23:0] raw, input logic make);
    raw_sample <= raw;
    raw_valid <= 1'b1;
    @(posedge hclk);
    raw_valid <= 1'b0;
    @(negedge hclk);
    if (make)
      m_res = model(raw);
    chk("result", m_res, conversion_result);
    @(posedge hclk);
  endtask
  initial
  begin
    logic [31:0] d;
    logic [23:0] q;
    logic [23:0] w;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    m_off = OFFSET_RESET;
    m_fs = FULLSCALE_RESET;
    m_fmt = 1'b0;
    m_res = 24'h000000;
    ahb(1'b0, 8'h10, 32'h00000000, d);
    chk("unmapped", 24'h000000, d[23:0]);
    chk("hresp", 24'h000000, {23'h000000, hresp});
    link(SEL_OFFSET, 1'b1, 24'h000000, q);
    chk("offset_rst", m_off, q);
    link(SEL_FULLSCALE, 1'b1, 24'h000000, q);
    chk("fullscale_rst", m_fs, q);
    // Readback in slave then master clocking
    for (int m = 0; m < 2; m++)
    begin
      mstr = m[0];
      ahb(1'b1, ADDR_CTRL, {27'h0000000, mstr, 4'h0}, d);
      sclk_master <= mstr;
      for (int s = 0; s < 2; s++)
      begin
        seed = lfsr(seed);
        w = seed[23:0];
        link(s[1:0], 1'b0, w, q);
        link(s[1:0], 1'b1, 24'h000000, q);
        chk("readback", w, q);
      end
    end
    // Corrections in both formats, gains 1, 2 and 3
    for (int i = 0; i < 6; i++)
    begin
      m_fmt = i[0];
      link(SEL_CTRL, 1'b0, {20'h00000, m_fmt, MODE_NORMAL}, q);
      seed = lfsr(seed);
      m_off = seed[23:0];
      link(SEL_OFFSET, 1'b0, m_off, q);
      m_fs = 24'(32'h00400000 * (i % 3 + 1));
      link(SEL_FULLSCALE, 1'b0, m_fs, q);
      seed = lfsr(seed);
      conv(seed[23:0], 1'b1);
      link(SEL_OFFSET, 1'b0, ~m_off, q);
      m_off = ~m_off;
      chk("held", m_res, conversion_result);
      ahb(1'b0, ADDR_STATUS, 32'h00000000, d);
      chk("ready", 24'h000001, {23'h000000, d[1]});
      link(SEL_RESULT, 1'b1, 24'h000000, q);
      chk("result_read", m_res, q);
      ahb(1'b0, ADDR_STATUS, 32'h00000000, d);
      chk("ready_clr", 24'h000000, {23'h000000, d[1]});
    end
    // Each calibration mode, then back to normal
    m_fmt = 1'b0;
    for (int md = 1; md < 5; md++)
    begin
      link(SEL_CTRL, 1'b0, {21'h000000, md[2:0]}, q);
      seed = lfsr(seed);
      conv(seed[23:0], 1'b0);
      if (md != 3)
        m_off = seed[23:0];
      if (md != 2)
        m_fs = FULLSCALE_RESET;
      link(SEL_OFFSET, 1'b1, 24'h000000, q);
      chk("cal_offset", m_off, q);
      link(SEL_FULLSCALE, 1'b1, 24'h000000, q);
      chk("cal_fullscale", m_fs, q);
      link(SEL_CTRL, 1'b1, 24'h000000, q);
      chk("mode", 24'h000000, q);
    end
    close_out();
  end
endmodule
